/* pkg/irq_ctrl_pkg.sv */
// constants and types shared by the interrupt controller files
package irq_ctrl_pkg;
    // -------------------------------------------------------------
    // special-function register addresses
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_EN_A    = 8'hA8;
    localparam logic [7:0] ADDR_PR_A    = 8'hB8;
    localparam logic [7:0] ADDR_EN_B    = 8'hB9;
    localparam logic [7:0] ADDR_PR_B    = 8'hBA;
    localparam logic [7:0] ADDR_EN_C    = 8'hBB;
    localparam logic [7:0] ADDR_PR_C    = 8'hBC;
    localparam logic [7:0] ADDR_TY_A    = 8'hBD;
    localparam logic [7:0] ADDR_TY_B    = 8'hBE;
    localparam logic [7:0] ADDR_PEND_A  = 8'hC0;
    localparam logic [7:0] ADDR_PEND_B  = 8'hC1;
    localparam logic [7:0] ADDR_PEND_C  = 8'hC2;
    localparam logic [7:0] ADDR_SEL_A   = 8'hC4;
    localparam logic [7:0] ADDR_SEL_B   = 8'hC6;
    // -------------------------------------------------------------
    // fields, reset values, vectors
    // -------------------------------------------------------------
    localparam int          GIE_BIT      = 7;
    localparam int          NUM_SLOTS    = 23;
    localparam int          NUM_PINS     = 13;
    localparam int          IDX_W        = 5;
    localparam logic [7:0]  REG_RESET    = 8'h00;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] VEC_BASE     = 16'h0003;
    localparam logic [15:0] VEC_LAST     = 16'h00B3;
    localparam logic [7:0]  READ_ZERO    = 8'h00;
    // -------------------------------------------------------------
    // in-service level, one-hot
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        SVC_NONE = 4'b0001,
        SVC_LOW  = 4'b0010,
        SVC_HIGH = 4'b0100,
        SVC_BOTH = 4'b1000
    } svc_t;
endpackage : irq_ctrl_pkg

/* design/irq_edge_detect.sv */
// per-bit edge detector with selectable polarity
`timescale 1ns/1ps
`default_nettype none
module irq_edge_detect #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] level_i,
    input  wire logic [W-1:0] rise_sel_i,
    output logic      [W-1:0] event_o
);
    generate
        if (W < 1)
        begin : g_bad_width
            $error("W must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [W-1:0] prev;
        logic         armed;
    } edge_state_t;

    edge_state_t st_q;
    edge_state_t st_d;

    // no edge in the first cycle after reset: prev is not yet real
    always_comb
    begin
        st_d       = st_q;
        st_d.prev  = level_i;
        st_d.armed = 1'b1;
        event_o    = {W{st_q.armed}} &
                     ((rise_sel_i & level_i & ~st_q.prev) |
                      (~rise_sel_i & ~level_i & st_q.prev));
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end
endmodule : irq_edge_detect
`default_nettype wire

/* design/irq_first_set.sv */
// lowest-index set bit finder
`timescale 1ns/1ps
`default_nettype none
module irq_first_set #(
    parameter int W  = 23,
    parameter int IW = 5
) (
    input  wire logic [W-1:0]  req_i,
    output logic               found_o,
    output logic      [IW-1:0] index_o
);
    generate
        if (W < 1 || (1 << IW) < W)
        begin : g_bad_width
            $error("IW too narrow for W");
        end
    endgenerate

    // scan from the top so the lowest index is left standing
    always_comb
    begin
        found_o = 1'b0;
        index_o = '0;
        for (int i = W - 1; i >= 0; i--)
        begin
            if (req_i[i])
            begin
                found_o = 1'b1;
                index_o = IW'(i);
            end
        end
    end
endmodule : irq_first_set
`default_nettype wire

/* design/irq_controller.sv */
// interrupt controller: enables, priorities, edges, pending flags, vectors
//
// Functional notes
// - A source asks the core for service only while its pending flag and its enable bit are both one.
// - Pending enabled requests are taken high group first, ties broken by lowest slot number.
// - Bit 7 of irq_enable_a gates every interrupt; when zero nothing is requested.
// - Reset vector is 0000H and slots 0..22 vector at 0003H plus eight per slot up to 00B3H.
// - irq_enable_a bits 6..0 enable timer 1, timer Y, timer X, serial 1 transmit, serial 1 receive, pin 1, pin 0.
// - irq_enable_b bits 7..0 enable A-D, pin 4, pin 3, pin 2, serial 2, counter 1, counter 0, timer 2.
// - irq_enable_c bits 7..0 enable pins 12, 11, 10, 9, 8, 7, 6 and 5 or their shared internal sources.
// - Priority bits sit at the enable positions, one means high group, bit 7 of irq_priority_a is reserved.
// - Pending flags sit at the enable positions, one means outstanding, bit 7 of irq_pending_a is reserved.
// - Each of pins 0..12 has an edge-select bit, zero falling and one rising.
// - irq_source_sel_a bits pick between the pin, counter, serial or A-D source and the alternate internal source.
// - irq_source_sel_b bits 4..0 route pins 9..5 or their internal sources, bits 7..5 reserved.
// - One switch input picks the first or second alternate pin set for pins 2, 3 and 4.
// - A key wake-up event fires when the AND of all input-mode key pins falls from one to zero.
// - All controller registers reset to zero except the one-hot in-service state, which resets to SVC_NONE (4'b0001).
`timescale 1ns/1ps
`default_nettype none
module irq_controller
    import irq_ctrl_pkg::*;
#(
    parameter int KEY_WIDTH = 8
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [7:0]           sfr_addr_i,
    input  wire logic                 sfr_wr_i,
    input  wire logic [7:0]           sfr_wdata_i,
    input  wire logic                 sfr_rd_i,
    output logic      [7:0]           sfr_rdata_o,
    input  wire logic [1:0]           ext_pin_irq_i,
    input  wire logic [7:0]           ext_pin_irq_upper_i,
    input  wire logic [2:0]           pin_irq_alt_a_i,
    input  wire logic [2:0]           pin_irq_alt_b_i,
    input  wire logic                 pin_alt_switch_i,
    input  wire logic [KEY_WIDTH-1:0] key_input_port_i,
    input  wire logic [KEY_WIDTH-1:0] key_dir_input_i,
    input  wire logic                 ibf_event_i,
    input  wire logic                 obe_event_i,
    input  wire logic                 sio1_rx_event_i,
    input  wire logic                 sio1_tx_event_i,
    input  wire logic                 i2c_line_event_i,
    input  wire logic                 timer_x_event_i,
    input  wire logic                 timer_y_event_i,
    input  wire logic                 timer_1_event_i,
    input  wire logic                 timer_2_event_i,
    input  wire logic                 counter_event_0_i,
    input  wire logic                 counter_event_1_i,
    input  wire logic                 sio2_event_i,
    input  wire logic                 i2c_event_i,
    input  wire logic                 adc_event_i,
    input  wire logic                 aux_i2c_irq_i,
    input  wire logic                 keyboard_ps2_irq_i,
    input  wire logic                 mouse_ps2_irq_i,
    input  wire logic                 internal_ps2_irq_i,
    input  wire logic                 aux_i2c_line_event_i,
    output logic                      irq_req_o,
    output logic      [15:0]          irq_vector_o,
    input  wire logic                 irq_ack_i,
    input  wire logic                 irq_return_i
);
    // -------------------------------------------------------------
    // elaboration check
    // -------------------------------------------------------------
    generate
        if (KEY_WIDTH < 1 || KEY_WIDTH > 8)
        begin : g_bad_key
            $error("KEY_WIDTH must be 1 to 8");
        end
    endgenerate

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0]           en_a;
        logic [7:0]           en_b;
        logic [7:0]           en_c;
        logic [6:0]           pr_a;
        logic [7:0]           pr_b;
        logic [7:0]           pr_c;
        logic [7:0]           ty_a;
        logic [4:0]           ty_b;
        logic [NUM_SLOTS-1:0] pend;
        logic [7:0]           sel_a;
        logic [4:0]           sel_b;
        svc_t                 svc;
        logic                 req;
        logic                 hi;
        logic [15:0]          vec;
        logic [7:0]           rdata;
    } state_t;

    state_t st_q;
    state_t st_d;

    // -------------------------------------------------------------
    // pin routing and edge detection
    // -------------------------------------------------------------
    logic [2:0]           alt_pins;
    logic [NUM_PINS-1:0]  pins;
    logic [NUM_PINS-1:0]  pin_ev;
    logic                 key_and;
    logic                 key_ev;

    assign alt_pins = pin_alt_switch_i ? pin_irq_alt_b_i : pin_irq_alt_a_i;
    assign pins     = {ext_pin_irq_upper_i, alt_pins, ext_pin_irq_i};
    // output-mode key pins are forced high so they never hold the AND low
    assign key_and  = &(key_input_port_i | ~key_dir_input_i);

    irq_edge_detect #(
        .W (NUM_PINS)
    ) u_pin_edge (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .level_i    (pins),
        .rise_sel_i ({st_q.ty_b, st_q.ty_a}),
        .event_o    (pin_ev)
    );

    irq_edge_detect #(
        .W (1)
    ) u_key_edge (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .level_i    (key_and),
        .rise_sel_i (1'b0),
        .event_o    (key_ev)
    );

    // -------------------------------------------------------------
    // source multiplexing, slot order equals vector order
    // -------------------------------------------------------------
    logic [NUM_SLOTS-1:0] set_ev;

    always_comb
    begin
        set_ev[0]  = st_q.sel_a[0] ? ibf_event_i : pin_ev[0];
        set_ev[1]  = st_q.sel_a[1] ? obe_event_i : pin_ev[1];
        set_ev[2]  = sio1_rx_event_i;
        set_ev[3]  = st_q.sel_a[2] ? i2c_line_event_i : sio1_tx_event_i;
        set_ev[4]  = timer_x_event_i;
        set_ev[5]  = timer_y_event_i;
        set_ev[6]  = timer_1_event_i;
        set_ev[7]  = timer_2_event_i;
        set_ev[8]  = st_q.sel_a[3] ? i2c_line_event_i : counter_event_0_i;
        set_ev[9]  = st_q.sel_a[6] ? key_ev : counter_event_1_i;
        set_ev[10] = st_q.sel_a[4] ? i2c_event_i : sio2_event_i;
        set_ev[11] = st_q.sel_a[5] ? i2c_event_i : pin_ev[2];
        set_ev[12] = pin_ev[3];
        set_ev[13] = pin_ev[4];
        set_ev[14] = st_q.sel_a[7] ? key_ev : adc_event_i;
        set_ev[15] = st_q.sel_b[0] ? aux_i2c_irq_i : pin_ev[5];
        set_ev[16] = st_q.sel_b[1] ? keyboard_ps2_irq_i : pin_ev[6];
        set_ev[17] = st_q.sel_b[2] ? mouse_ps2_irq_i : pin_ev[7];
        set_ev[18] = st_q.sel_b[3] ? internal_ps2_irq_i : pin_ev[8];
        set_ev[19] = st_q.sel_b[4] ? aux_i2c_line_event_i : pin_ev[9];
        set_ev[20] = pin_ev[10];
        set_ev[21] = pin_ev[11];
        set_ev[22] = pin_ev[12];
    end

    // -------------------------------------------------------------
    // arbitration
    // -------------------------------------------------------------
    logic [NUM_SLOTS-1:0] en_all;
    logic [NUM_SLOTS-1:0] pr_all;
    logic [NUM_SLOTS-1:0] live;
    logic                 hi_found;
    logic                 lo_found;
    logic [IDX_W-1:0]     hi_idx;
    logic [IDX_W-1:0]     lo_idx;
    logic                 take_hi;
    logic                 take_lo;
    logic [IDX_W-1:0]     win_idx;
    logic                 take_ack;

    assign en_all = {st_q.en_c, st_q.en_b, st_q.en_a[6:0]};
    assign pr_all = {st_q.pr_c, st_q.pr_b, st_q.pr_a};
    assign live   = st_q.pend & en_all & {NUM_SLOTS{st_q.en_a[GIE_BIT]}};

    irq_first_set #(
        .W  (NUM_SLOTS),
        .IW (IDX_W)
    ) u_hi_pick (
        .req_i   (live & pr_all),
        .found_o (hi_found),
        .index_o (hi_idx)
    );

    irq_first_set #(
        .W  (NUM_SLOTS),
        .IW (IDX_W)
    ) u_lo_pick (
        .req_i   (live & ~pr_all),
        .found_o (lo_found),
        .index_o (lo_idx)
    );

    // high group beats low, lowest slot wins inside a group
    assign take_hi  = hi_found && st_q.svc != SVC_HIGH && st_q.svc != SVC_BOTH;
    assign take_lo  = lo_found && st_q.svc == SVC_NONE;
    assign win_idx  = take_hi ? hi_idx : lo_idx;
    assign take_ack = irq_ack_i && st_q.req;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    logic wr_en;

    assign wr_en = sfr_wr_i;

    always_comb
    begin
        st_d = st_q;
        // set beats a software clear in the same cycle
        st_d.pend = st_q.pend | set_ev;
        if (wr_en)
        begin
            case (sfr_addr_i)
                ADDR_EN_A:   st_d.en_a  = sfr_wdata_i;
                ADDR_EN_B:   st_d.en_b  = sfr_wdata_i;
                ADDR_EN_C:   st_d.en_c  = sfr_wdata_i;
                ADDR_PR_A:   st_d.pr_a  = sfr_wdata_i[6:0];
                ADDR_PR_B:   st_d.pr_b  = sfr_wdata_i;
                ADDR_PR_C:   st_d.pr_c  = sfr_wdata_i;
                ADDR_TY_A:   st_d.ty_a  = sfr_wdata_i;
                ADDR_TY_B:   st_d.ty_b  = sfr_wdata_i[4:0];
                ADDR_SEL_A:  st_d.sel_a = sfr_wdata_i;
                ADDR_SEL_B:  st_d.sel_b = sfr_wdata_i[4:0];
                ADDR_PEND_A: st_d.pend[6:0]   = sfr_wdata_i[6:0] | set_ev[6:0];
                ADDR_PEND_B: st_d.pend[14:7]  = sfr_wdata_i | set_ev[14:7];
                ADDR_PEND_C: st_d.pend[22:15] = sfr_wdata_i | set_ev[22:15];
                default:     st_d.pend = st_q.pend | set_ev;
            endcase
        end

        // registered read port; unmapped and reserved bits read zero
        if (sfr_rd_i)
        begin
            case (sfr_addr_i)
                ADDR_EN_A:   st_d.rdata = st_q.en_a;
                ADDR_EN_B:   st_d.rdata = st_q.en_b;
                ADDR_EN_C:   st_d.rdata = st_q.en_c;
                ADDR_PR_A:   st_d.rdata = {1'b0, st_q.pr_a};
                ADDR_PR_B:   st_d.rdata = st_q.pr_b;
                ADDR_PR_C:   st_d.rdata = st_q.pr_c;
                ADDR_TY_A:   st_d.rdata = st_q.ty_a;
                ADDR_TY_B:   st_d.rdata = {3'h0, st_q.ty_b};
                ADDR_PEND_A: st_d.rdata = {1'b0, st_q.pend[6:0]};
                ADDR_PEND_B: st_d.rdata = st_q.pend[14:7];
                ADDR_PEND_C: st_d.rdata = st_q.pend[22:15];
                ADDR_SEL_A:  st_d.rdata = st_q.sel_a;
                ADDR_SEL_B:  st_d.rdata = {3'h0, st_q.sel_b};
                default:     st_d.rdata = READ_ZERO;
            endcase
        end

        // in-service tracking, pending is left for software to clear
        unique case (st_q.svc)
            SVC_NONE:
            begin
                if (take_ack)
                    st_d.svc = st_q.hi ? SVC_HIGH : SVC_LOW;
            end
            SVC_LOW:
            begin
                if (take_ack && st_q.hi)
                    st_d.svc = SVC_BOTH;
                else if (irq_return_i)
                    st_d.svc = SVC_NONE;
            end
            SVC_HIGH:
            begin
                if (irq_return_i)
                    st_d.svc = SVC_NONE;
            end
            SVC_BOTH:
            begin
                if (irq_return_i)
                    st_d.svc = SVC_LOW;
            end
            default: st_d.svc = SVC_NONE;
        endcase

        // drop the request on acknowledge; in-service state updates on the same edge
        st_d.req = (take_hi || take_lo) && !take_ack;
        st_d.hi  = take_hi;
        if (take_hi || take_lo)
            st_d.vec = VEC_BASE + 16'({win_idx, 3'b000});
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q       <= '0;
            st_q.svc   <= SVC_NONE;
            st_q.vec   <= RESET_VECTOR;
            st_q.rdata <= REG_RESET;
        end
        else
            st_q <= st_d;
    end

    assign sfr_rdata_o  = st_q.rdata;
    assign irq_req_o    = st_q.req;
    assign irq_vector_o = st_q.vec;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    req_needs_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        irq_req_o |-> $past(|(st_q.pend & en_all)))
        else $error("request without pending enabled source");

    global_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !st_q.en_a[GIE_BIT] |=> !irq_req_o)
        else $error("request while global enable is off");

    vector_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        irq_req_o |-> (irq_vector_o >= VEC_BASE && irq_vector_o <= VEC_LAST && irq_vector_o[2:0] == 3'h3))
        else $error("vector outside table");

    high_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (hi_found && lo_found && st_q.svc == SVC_NONE && !irq_ack_i) |=> (irq_req_o && st_q.hi))
        else $error("low group taken before high group");

    set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (|set_ev) |=> ((st_q.pend & $past(set_ev)) == $past(set_ev)))
        else $error("event lost in pending flags");

    low_svc_enter_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.svc == SVC_NONE && take_ack && !st_q.hi) |=> (st_q.svc == SVC_LOW && !irq_req_o))
        else $error("low acknowledge did not enter low service");

    high_blocks_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.svc == SVC_HIGH && $past(st_q.svc) == SVC_HIGH) |-> !irq_req_o)
        else $error("request during high service");

    key_wake_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (key_ev && st_q.sel_a[7]) |=> st_q.pend[14])
        else $error("key wake-up not recorded");

    reserved_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(sfr_rd_i && (sfr_addr_i == ADDR_PEND_A || sfr_addr_i == ADDR_PR_A)) |-> !sfr_rdata_o[7])
        else $error("reserved bit reads one");
endmodule : irq_controller
`default_nettype wire

/* verif/core_model.sv */
// behavioural processor core: takes vectors, serves, returns
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        req_i,
    input  wire logic [15:0] vec_i,
    input  wire logic        auto_i,
    input  wire logic [3:0]  dly_i,
    input  wire logic [7:0]  svc_i,
    output logic             ack_o,
    output logic             ret_o,
    output logic      [15:0] vec_o,
    output logic      [7:0]  cnt_o
);
    logic [3:0] wait_q;
    logic [7:0] tmr_q;
    logic [1:0] depth_q;
    // acts on the falling edge so the controller samples settled pulses
    always @(negedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_o   <= 1'b0;
            ret_o   <= 1'b0;
            vec_o   <= 16'h0000;
            cnt_o   <= 8'h00;
            wait_q  <= 4'h0;
            tmr_q   <= 8'h00;
            depth_q <= 2'h0;
        end
        else
        begin
            ack_o <= 1'b0;
            ret_o <= 1'b0;
            if (auto_i && req_i && !ack_o && wait_q == dly_i)
            begin
                ack_o   <= 1'b1;
                vec_o   <= vec_i;
                cnt_o   <= cnt_o + 8'h01;
                depth_q <= depth_q + 2'h1;
                tmr_q   <= svc_i;
                wait_q  <= 4'h0;
            end
            else if (auto_i && req_i && !ack_o)
                wait_q <= wait_q + 4'h1;
            else if (depth_q != 2'h0 && tmr_q == 8'h00)
            begin
                // one level unwinds per return pulse, innermost first
                ret_o   <= 1'b1;
                depth_q <= depth_q - 2'h1;
                tmr_q   <= svc_i;
            end
            else if (tmr_q != 8'h00)
                tmr_q <= tmr_q - 8'h01;
        end
    end
endmodule : core_model
`default_nettype wire

/* verif/irq_controller_bench.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_controller_bench;
    localparam int LIMIT = 6000;
    localparam logic [7:0] RA [13] = '{8'hA8, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD,
                                       8'hBE, 8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'hC6};
    localparam logic [7:0] RM [13] = '{8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                       8'h1F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h1F};
    localparam logic [7:0] EN [3] = '{8'hA8, 8'hB9, 8'hBB};
    localparam logic [7:0] PN [3] = '{8'hC0, 8'hC1, 8'hC2};
    // select addr, select value, pending addr, expected flags
    localparam logic [31:0] EVT [19] = '{32'hC401C001, 32'hC402C002, 32'hC400C004, 32'hC400C008,
        32'hC404C008, 32'hC400C010, 32'hC400C020, 32'hC400C040, 32'hC400C101, 32'hC400C102,
        32'hC400C104, 32'hC400C108, 32'hC420C110, 32'hC400C180, 32'hC601C201, 32'hC602C202,
        32'hC604C204, 32'hC608C208, 32'hC610C210};
    logic        clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, pin_alt_switch_i, irq_req_o;
    logic        auto, irq_ack_i, irq_return_i;
    logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, ext_pin_irq_upper_i;
    logic [7:0]  key_input_port_i, key_dir_input_i, svc, cnt, m;
    logic [1:0]  ext_pin_irq_i;
    logic [2:0]  pin_irq_alt_a_i, pin_irq_alt_b_i;
    logic [3:0]  dly;
    logic [15:0] irq_vector_o, tvec;
    logic [18:0] ev;
    int          error_cnt, tests_run, cyc, i, g;
    wire logic   aux_i2c_line_event_i, internal_ps2_irq_i, mouse_ps2_irq_i, keyboard_ps2_irq_i;
    wire logic   aux_i2c_irq_i, adc_event_i, i2c_event_i, sio2_event_i, counter_event_1_i;
    wire logic   counter_event_0_i, timer_2_event_i, timer_1_event_i, timer_y_event_i;
    wire logic   timer_x_event_i, i2c_line_event_i, sio1_tx_event_i, sio1_rx_event_i;
    wire logic   obe_event_i, ibf_event_i;
    assign {aux_i2c_line_event_i, internal_ps2_irq_i, mouse_ps2_irq_i, keyboard_ps2_irq_i,
            aux_i2c_irq_i, adc_event_i, i2c_event_i, sio2_event_i, counter_event_1_i,
            counter_event_0_i, timer_2_event_i, timer_1_event_i, timer_y_event_i, timer_x_event_i,
            i2c_line_event_i, sio1_tx_event_i, sio1_rx_event_i, obe_event_i, ibf_event_i} = ev;
    irq_controller #(.KEY_WIDTH(8)) DUT (.*);
    core_model CORE (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(irq_req_o), .vec_i(irq_vector_o),
        .auto_i(auto), .dly_i(dly), .svc_i(svc), .ack_o(irq_ack_i), .ret_o(irq_return_i),
        .vec_o(tvec), .cnt_o(cnt));
    // ---------------------------------------------
    // access and checking tasks
    // ---------------------------------------------
    task step(input int n);
        repeat (n) @(negedge clk_i);
    endtask : step
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge clk_i);
        sfr_wr_i = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge clk_i);
        sfr_rd_i = 1'b0;
        chk($sformatf("reg %h", a), {8'h00, sfr_rdata_o}, {8'h00, e});
    endtask : rd
    task wcnt(input logic [7:0] n);
        int k;
        k = 0;
        while (cnt !== n && k < 20)
        begin
            @(negedge clk_i);
            k++;
        end
        chk("acks", {8'h00, cnt}, {8'h00, n});
    endtask : wcnt
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial
    begin
        {rst_n_i, sfr_wr_i, sfr_rd_i, pin_alt_switch_i, auto, sfr_addr_i, sfr_wdata_i} = '0;
        {ev, dly, svc, error_cnt, tests_run} = '0;
        {ext_pin_irq_i, ext_pin_irq_upper_i, pin_irq_alt_a_i, pin_irq_alt_b_i} = '1;
        key_input_port_i = 8'hFF;
        key_dir_input_i = 8'h0F;
        step(8);
        rst_n_i = 1'b1;
        step(2);
        for (i = 0; i < 13; i++) rd(RA[i], 8'h00);
        rd(8'hC3, 8'h00);
        for (i = 0; i < 13; i++) wr(RA[i], 8'hFF);
        for (i = 0; i < 13; i++) rd(RA[i], RM[i]);
        for (i = 0; i < 13; i++) wr(RA[i], 8'h00);
        wr(8'hA8, 8'h80);
        for (i = 0; i < 23; i++)
        begin
            g = (i < 7) ? 0 : (i < 15) ? 1 : 2;
            m = 8'h01 << (i - ((g == 0) ? 0 : (g == 1) ? 7 : 15));
            wr(EN[g], m | ((g == 0) ? 8'h80 : 8'h00));
            wr(PN[g], m);
            step(3);
            chk("vector", irq_vector_o, 16'h0003 + 16'(8 * i));
            wr(PN[g], 8'h00);
            wr(EN[g], (g == 0) ? 8'h80 : 8'h00);
        end
        wr(8'hA8, 8'h01);
        wr(8'hC0, 8'h01);
        step(3);
        chk("gated", {15'h0, irq_req_o}, 16'h0000);
        wr(8'hA8, 8'h81);
        step(3);
        chk("open", {15'h0, irq_req_o}, 16'h0001);
        wr(8'hA8, 8'h80);
        step(3);
        chk("masked", {15'h0, irq_req_o}, 16'h0000);
        wr(8'hA8, 8'h86);
        wr(8'hC0, 8'h06);
        step(3);
        chk("tie", irq_vector_o, 16'h000B);
        wr(8'hB8, 8'h04);
        step(3);
        chk("group", irq_vector_o, 16'h0013);
        wr(8'hB8, 8'h02);
        wr(8'hA8, 8'h87);
        wr(8'hC0, 8'h01);
        {auto, svc} <= {1'b1, 8'h3C};
        wcnt(8'h01);
        chk("low taken", tvec, 16'h0003);
        wr(8'hC0, 8'h05);
        step(6);
        chk("no nest", {8'h00, cnt}, 16'h0001);
        dly <= 4'h3;
        wr(8'hC0, 8'h02);
        wcnt(8'h02);
        chk("preempt", tvec, 16'h000B);
        wr(8'hC0, 8'h00);
        step(140);
        wr(8'hC0, 8'h02);
        wcnt(8'h03);
        chk("high taken", tvec, 16'h000B);
        wr(8'hC0, 8'h06);
        step(6);
        chk("high alone", {8'h00, cnt}, 16'h0003);
        wr(8'hC0, 8'h00);
        auto <= 1'b0;
        step(70);
        wr(8'hC0, 8'h01);
        step(3);
        chk("returned", {15'h0, irq_req_o}, 16'h0001);
        wr(8'hC0, 8'h00);
        for (i = 0; i < 19; i++)
        begin
            wr(EVT[i][31:24], EVT[i][23:16]);
            ev[i] = 1'b1;
            @(negedge clk_i);
            ev[i] = 1'b0;
            rd(EVT[i][15:8], EVT[i][7:0]);
            wr(EVT[i][15:8], 8'h00);
            wr(EVT[i][31:24], 8'h00);
        end
        ext_pin_irq_i[0] = 1'b0;
        step(2);
        rd(8'hC0, 8'h01);
        wr(8'hC0, 8'h00);
        rd(8'hC0, 8'h00);
        wr(8'hBE, 8'h10);
        ext_pin_irq_upper_i[7] = 1'b0;
        step(2);
        rd(8'hC2, 8'h00);
        ext_pin_irq_upper_i[7] = 1'b1;
        step(2);
        rd(8'hC2, 8'h80);
        wr(8'hC2, 8'h00);
        pin_irq_alt_b_i[0] = 1'b0;
        step(2);
        rd(8'hC1, 8'h00);
        pin_alt_switch_i = 1'b1;
        step(2);
        rd(8'hC1, 8'h10);
        wr(8'hC1, 8'h00);
        wr(8'hC4, 8'hC0);
        key_input_port_i[7] = 1'b0;
        step(2);
        rd(8'hC1, 8'h00);
        key_input_port_i[1] = 1'b0;
        step(2);
        rd(8'hC1, 8'h84);
        rst_n_i = 1'b0;
        step(2);
        rst_n_i = 1'b1;
        for (i = 0; i < 13; i++) rd(RA[i], 8'h00);
        tally_and_finish();
    end
endmodule : irq_controller_bench
`default_nettype wire
